// [hdl/twcp_defs.vh]
`ifndef TWCP_DEFS_VH
`define TWCP_DEFS_VH
`define TWCP_LEN_8       5'h08
`define TWCP_LEN_16      5'h10
`define TWCP_LEN_24      5'h18
`define TWCP_CNT_W       5
`define TWCP_SHIFT_W     24
`define TWCP_A8_HI       7
`define TWCP_A8_LO       6
`define TWCP_A16_HI      7
`define TWCP_A16_LO      6
`define TWCP_A24_HI      7
`define TWCP_A24_LO      6
`define TWCP_GAIN_HI     9
`define TWCP_GAIN_LO     6
`define TWCP_R8_RST      8'h00
`define TWCP_R16_RST     16'h0000
`define TWCP_R24_RST     24'h000000
`define TWCP_PIN_IDLE    3'h1
`define TWCP_CNT_ZERO    5'h00
`define TWCP_GAIN_RST    4'h0
`define TWCP_GAIN_ADDR   2'h0
`define TWCP_W8          8
`define TWCP_W16         16
`define TWCP_W24         24
`endif

// [hdl/twcp_port.v]
`timescale 1ns/1ps
`default_nettype none
`include "twcp_defs.vh"
module twcp_port #(
  parameter NREG    = 4,
  parameter SHIFT_W = `TWCP_SHIFT_W,
  parameter CNT_W   = `TWCP_CNT_W
) (
  input  wire                clk,
  input  wire                sys_rst,
  input  wire                bus_en_n,
  input  wire                bus_clk,
  input  wire                bus_data,
  output wire [NREG*8-1:0]   reg8_flat,
  output wire [NREG*16-1:0]  reg16_flat,
  output wire [NREG*24-1:0]  reg24_flat,
  output reg  [3:0]          if_gain,
  output reg                 write_strobe
);
  // ------------------------------------------------------------------
  // constants
  // ------------------------------------------------------------------
  localparam       NPIN      = 3;
  localparam [2:0] PIN_IDLE  = `TWCP_PIN_IDLE;
  localparam [2:0] ST_IDLE   = 3'h1;
  localparam [2:0] ST_RECV   = 3'h2;
  localparam [2:0] ST_OVER   = 3'h4;

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  wire [NPIN-1:0] pin_raw;
  reg  [NPIN-1:0] pin_meta;
  reg  [NPIN-1:0] pin_sync;

  assign pin_raw = {bus_data, bus_clk, bus_en_n};

  genvar p;
  generate
    for (p = 0; p < NPIN; p = p + 1) begin : g_pin
      // two flops per pin; only the second one is read by logic
      always @(posedge clk) begin
        if (sys_rst) begin
          pin_meta[p] <= PIN_IDLE[p];
          pin_sync[p] <= PIN_IDLE[p];
        end else begin
          pin_meta[p] <= pin_raw[p];
          pin_sync[p] <= pin_meta[p];
        end
      end
    end
  endgenerate

  wire en_sync = pin_sync[0];
  wire ck_sync = pin_sync[1];
  wire dt_sync = pin_sync[2];

  // ------------------------------------------------------------------
  // edge detection
  // ------------------------------------------------------------------
  reg en_prev;
  reg ck_prev;

  // idle levels after reset, so no false edge follows reset
  always @(posedge clk) begin
    if (sys_rst) begin
      en_prev <= PIN_IDLE[0];
      ck_prev <= PIN_IDLE[1];
    end else begin
      en_prev <= en_sync;
      ck_prev <= ck_sync;
    end
  end

  wire en_low  = ~en_sync;
  wire en_fall = en_prev & ~en_sync;
  wire en_rise = ~en_prev & en_sync;
  wire ck_rise = ~ck_prev & ck_sync;

  // ------------------------------------------------------------------
  // frame state machine
  // ------------------------------------------------------------------
  reg  [2:0]       state;
  reg  [2:0]       next_state;
  reg  [CNT_W-1:0] count;
  wire             shift_en;
  wire [CNT_W:0]   count_sum;
  wire             count_wrap;

  assign shift_en   = en_low & ck_rise & (state != ST_IDLE);
  assign count_sum  = {1'h0, count} + {{CNT_W{1'h0}}, 1'h1};
  assign count_wrap = shift_en & count_sum[CNT_W];

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (en_fall)
          next_state = ST_RECV;
      end
      ST_RECV: begin
        if (en_rise)
          next_state = ST_IDLE;
        else if (count_wrap)
          next_state = ST_OVER;
      end
      ST_OVER: begin
        // too many edges: wait for frame end, load nothing
        if (en_rise)
          next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ------------------------------------------------------------------
  // edge counter
  // ------------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      count <= `TWCP_CNT_ZERO;
    end else if (en_fall) begin
      count <= `TWCP_CNT_ZERO;
    end else if (shift_en) begin
      count <= count_sum[CNT_W-1:0];
    end
  end

  // ------------------------------------------------------------------
  // receive shift register
  // ------------------------------------------------------------------
  reg [SHIFT_W-1:0] shift;

  always @(posedge clk) begin
    if (sys_rst) begin
      shift <= `TWCP_R24_RST;
    end else if (shift_en) begin
      shift <= {shift[SHIFT_W-2:0], dt_sync};
    end
  end

  // ------------------------------------------------------------------
  // length decode
  // ------------------------------------------------------------------
  wire commit = en_rise & (state == ST_RECV);
  wire load8  = commit & (count == `TWCP_LEN_8);
  wire load16 = commit & (count == `TWCP_LEN_16);
  wire load24 = commit & (count == `TWCP_LEN_24);

  // ------------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------------
  wire [1:0]      addr8;
  wire [1:0]      addr16;
  wire [1:0]      addr24;
  wire [NREG-1:0] sel8;
  wire [NREG-1:0] sel16;
  wire [NREG-1:0] sel24;

  assign addr8  = shift[`TWCP_A8_HI:`TWCP_A8_LO];
  assign addr16 = shift[`TWCP_A16_HI:`TWCP_A16_LO];
  assign addr24 = shift[`TWCP_A24_HI:`TWCP_A24_LO];
  assign sel8   = {{(NREG-1){1'h0}}, 1'h1} << addr8;
  assign sel16  = {{(NREG-1){1'h0}}, 1'h1} << addr16;
  assign sel24  = {{(NREG-1){1'h0}}, 1'h1} << addr24;

  // ------------------------------------------------------------------
  // register bank
  // ------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NREG; g = g + 1) begin : g_slot
      reg [`TWCP_W8-1:0]  r8;
      reg [`TWCP_W16-1:0] r16;
      reg [`TWCP_W24-1:0] r24;

      // a whole register is replaced at once, never a part
      always @(posedge clk) begin
        if (sys_rst) begin
          r8  <= `TWCP_R8_RST;
          r16 <= `TWCP_R16_RST;
          r24 <= `TWCP_R24_RST;
        end else begin
          if (load8 && sel8[g]) begin
            r8 <= shift[`TWCP_W8-1:0];
          end
          if (load16 && sel16[g]) begin
            r16 <= shift[`TWCP_W16-1:0];
          end
          if (load24 && sel24[g]) begin
            r24 <= shift[`TWCP_W24-1:0];
          end
        end
      end

      assign reg8_flat[g*`TWCP_W8 +: `TWCP_W8]    = r8;
      assign reg16_flat[g*`TWCP_W16 +: `TWCP_W16] = r16;
      assign reg24_flat[g*`TWCP_W24 +: `TWCP_W24] = r24;
    end
  endgenerate

  // ------------------------------------------------------------------
  // gain field and load strobe
  // ------------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      if_gain      <= `TWCP_GAIN_RST;
      write_strobe <= 1'h0;
    end else begin
      write_strobe <= load8 | load16 | load24;
      if (load16 && addr16 == `TWCP_GAIN_ADDR) begin
        if_gain <= shift[`TWCP_GAIN_HI:`TWCP_GAIN_LO];
      end
    end
  end

endmodule // twcp_port
`default_nettype wire

// [verif/twcp_host.sv]
`timescale 1ns/1ps
`default_nettype none
module twcp_host (
  output var logic bus_en_n,
  output var logic bus_clk,
  output var logic bus_data
);
  initial {bus_en_n, bus_clk, bus_data} = 3'h4;
  task automatic send(input int n, input logic [23:0] d);
    bus_en_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      bus_data = d[i];
      #62.5 bus_clk = 1'b1;
      #62.5 bus_clk = 1'b0;
    end
    bus_en_n = 1'b1;
    bus_data = ~bus_data;
    #300;
  endtask
endmodule // twcp_host
`default_nettype wire

// [verif/twcp_port_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module twcp_chk (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        bus_en_n,
  input wire logic [31:0] reg8_flat,
  input wire logic [63:0] reg16_flat,
  input wire logic [95:0] reg24_flat,
  input wire logic [3:0]  if_gain,
  input wire logic        write_strobe
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_PULSE: assert property (write_strobe |=> !write_strobe)
    else $error("long strobe");
  AST_R8: assert property (!$stable(reg8_flat) |-> write_strobe)
    else $error("r8 moved");
  AST_R16: assert property (!$stable(reg16_flat) |-> write_strobe)
    else $error("r16 moved");
  AST_R24: assert property (!$stable(reg24_flat) |-> write_strobe)
    else $error("r24 moved");
  AST_ONE: assert property ($onehot0({!$stable(reg8_flat),
    !$stable(reg16_flat), !$stable(reg24_flat)})) else $error("two");
  AST_GAIN: assert property (if_gain == reg16_flat[9:6])
    else $error("gain");
  AST_EN: assert property (write_strobe |-> $past(bus_en_n, 2))
    else $error("early load");
  AST_ADR: assert property (!$stable(reg8_flat[31:24]) |->
    reg8_flat[31:30] == 2'h3) else $error("addr");
endmodule // twcp_chk
bind twcp_port twcp_chk u_chk (.clk, .sys_rst, .bus_en_n, .reg8_flat,
  .reg16_flat, .reg24_flat, .if_gain, .write_strobe);
`default_nettype wire

// [verif/twcp_port_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module twcp_port_tb_top;
  logic         clk, sys_rst;
  wire          bus_en_n, bus_clk, bus_data, write_strobe;
  wire  [31:0]  reg8_flat;
  wire  [63:0]  reg16_flat;
  wire  [95:0]  reg24_flat;
  wire  [3:0]   if_gain;
  wire  [195:0] seen = {if_gain, reg8_flat, reg16_flat, reg24_flat};
  logic [195:0] q[$];
  logic [31:0]  e8 = '0;
  logic [63:0]  e16 = '0;
  logic [95:0]  e24 = '0;
  logic [23:0]  d;
  int           errors = 0, checks_done = 0;
  int           lens[6] = '{8, 7, 16, 9, 24, 23};
  twcp_port DUT (.clk, .sys_rst, .bus_en_n, .bus_clk, .bus_data,
    .reg8_flat, .reg16_flat, .reg24_flat, .if_gain, .write_strobe);
  twcp_host host (.bus_en_n, .bus_clk, .bus_data);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task chk(input logic [195:0] s, input logic [195:0] e);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH regs exp %h got %h", e, s);
    end
  endtask
  task summarize;
    if (errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(negedge clk) if (write_strobe === 1'b1)
    chk(seen, q.size() ? q.pop_front() : 'x);
  initial begin
    sys_rst = 1'b1;
    void'($urandom(9478));
    repeat (5) @(posedge clk);
    #1 sys_rst = 1'b0;
    chk(seen, '0);
    foreach (lens[i]) for (int a = 0; a < 4; a++) begin
      d = $urandom;
      d[7:6] = a[1:0];
      if (lens[i] == 24 && a < 2) d[5:2] = 4'h0;
      case (lens[i])
        8: e8[a*8 +: 8] = d[7:0];
        16: e16[a*16 +: 16] = d[15:0];
        24: e24[a*24 +: 24] = d;
      endcase
      if (lens[i] % 8 == 0) q.push_back({e16[9:6], e8, e16, e24});
      @(posedge clk) #1;
      host.send(lens[i], d);
    end
    for (int t = 0; t < 50 && q.size() > 0; t++) @(posedge clk);
    if (q.size() > 0) errors++;
    chk(seen, {e16[9:6], e8, e16, e24});
    summarize;
  end
endmodule // twcp_port_tb_top
`default_nettype wire
